// file: common/tolrb_defines.vh
/*
 * Constants for the tolerance readback two-wire target: locations,
 * instruction fields, bus addresses, states and counts.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef TOLRB_DEFINES_VH
`define TOLRB_DEFINES_VH

// ****************************************************************
// Memory locations and instruction fields
// ****************************************************************
`define TOLRB_LOC_SIGN_INT   5'h1e
`define TOLRB_LOC_FRACTION   5'h1f
`define TOLRB_CMD_EEPROM     3'h1
`define TOLRB_CMD_MSB        7
`define TOLRB_CMD_LSB        5
`define TOLRB_LOC_MSB        4
`define TOLRB_LOC_LSB        0
`define TOLRB_BYTE_MSB       7
`define TOLRB_RW_BIT         0
`define TOLRB_EMPTY_BYTE     8'h00
`define TOLRB_RESET_CMD      3'h0
`define TOLRB_RESET_LOC      5'h00
`define TOLRB_LOC_STEP       5'h01

// ****************************************************************
// Target addresses selected by the straps {high, low}
// ****************************************************************
`define TOLRB_ADDR_00        7'h18
`define TOLRB_ADDR_10        7'h1a
`define TOLRB_ADDR_01        7'h4c
`define TOLRB_ADDR_11        7'h4e

// ****************************************************************
// Counts
// ****************************************************************
`define TOLRB_BITS_PER_BYTE  4'h8
`define TOLRB_LAST_BIT       4'h7
`define TOLRB_BIT_ZERO       4'h0
`define TOLRB_BIT_STEP       4'h1
`define TOLRB_STRAP_SETTLE   2'h3
`define TOLRB_STRAP_STEP     2'h1
`define TOLRB_STRAP_ZERO     2'h0

// ****************************************************************
// Protocol states
// ****************************************************************
`define TOLRB_ST_IDLE        4'h0
`define TOLRB_ST_ADDR        4'h1
`define TOLRB_ST_ADDR_ACK    4'h2
`define TOLRB_ST_INSTR       4'h3
`define TOLRB_ST_INSTR_ACK   4'h4
`define TOLRB_ST_WDATA       4'h5
`define TOLRB_ST_WDATA_ACK   4'h6
`define TOLRB_ST_RDATA       4'h7
`define TOLRB_ST_RACK        4'h8

`endif

// file: hdl/tolrb_sync.v
/*
 * Two flip-flop synchroniser for one level from outside the clock domain.
 * Assumes clk is the block clock and nrst an asynchronous active-low reset.
 */
`timescale 1ns/1ps
module tolrb_sync #(
	parameter RESET_VALUE = 1'b1
) (
	// Clock and reset
	input  wire clk,
	input  wire nrst,
	// Level in and out
	input  wire async_in,
	output reg  sync_out
);

reg meta;

always @(posedge clk or negedge nrst) begin
	if (!nrst) begin
		meta     <= RESET_VALUE;
		sync_out <= RESET_VALUE;
	end else begin
		meta     <= async_in;
		sync_out <= meta;
	end
end

endmodule // tolrb_sync

// file: hdl/tolrb_target.v
/*
 * Two-wire serial target that returns the factory resistance tolerance:
 * instruction write sets operation and location, reads return bytes.
 * Assumes SCL and SDA arrive as pins sampled by clk, SDA is open drain
 * resolved outside, and straps are stable before reset is released.
 */
// Behaviour
// - Tolerance held read-only: sign and integer at 11110, fraction at 11111.
// - Tolerance bytes readable any time, no unlock or special mode needed.
// - Single fetch: instruction, repeated start, read one byte, no ack, stop.
// - Combined fetch: point at 11110, read, ack, read second, no ack, stop.
// - After an acknowledged read byte the location pointer advances 11110 to 11111.
// - First byte bit 7 is sign, 0 positive; low seven bits integer percent.
// - Second byte is unsigned fraction, each count one 256th percent.
// - Instruction top three bits select operation; 001 means memory, low five location.
// - Straps sampled at power-up select one of four 7-bit target addresses.
`timescale 1ns/1ps
`include "tolrb_defines.vh"
module tolrb_target #(
	parameter [7:0] TOL_SIGN_INT = 8'h00,
	parameter [7:0] TOL_FRACTION = 8'h00
) (
	// Clock and reset
	input  wire       clk,
	input  wire       nrst,
	// Two-wire bus
	input  wire       scl_in,
	input  wire       sda_in,
	output wire       sda_out,
	output reg        sda_oe_n,
	// Address straps
	input  wire       bus_id_strap_low,
	input  wire       bus_id_strap_high,
	// Status
	output reg  [6:0] bus_address,
	output reg        address_valid
);

// ****************************************************************
// Decoding
// ****************************************************************
function [6:0] strap_address;
	input high;
	input low;
	begin
		case ({high, low})
			2'h0:    strap_address = `TOLRB_ADDR_00;
			2'h2:    strap_address = `TOLRB_ADDR_10;
			2'h1:    strap_address = `TOLRB_ADDR_01;
			default: strap_address = `TOLRB_ADDR_11;
		endcase
	end
endfunction

// Only the memory operation at the two tolerance locations returns data
function [7:0] read_byte;
	input [2:0] cmd;
	input [4:0] loc;
	begin
		read_byte = `TOLRB_EMPTY_BYTE;
		if (cmd == `TOLRB_CMD_EEPROM) begin
			if (loc == `TOLRB_LOC_SIGN_INT)
				read_byte = TOL_SIGN_INT;
			else if (loc == `TOLRB_LOC_FRACTION)
				read_byte = TOL_FRACTION;
		end
	end
endfunction

// ****************************************************************
// Input synchronisers
// ****************************************************************
wire [3:0] pin_async = {bus_id_strap_high, bus_id_strap_low, sda_in, scl_in};
wire [3:0] pin_sync;

genvar g;
generate
	for (g = 0; g < 4; g = g + 1) begin : g_sync
		tolrb_sync #(
			.RESET_VALUE (1'b1)
		) u_sync (
			.clk      (clk),
			.nrst     (nrst),
			.async_in (pin_async[g]),
			.sync_out (pin_sync[g])
		);
	end
endgenerate

wire scl_s = pin_sync[0];
wire sda_s = pin_sync[1];

reg scl_p;
reg sda_p;

wire scl_rise  = scl_s & ~scl_p;
wire scl_fall  = ~scl_s & scl_p;
wire bus_start = scl_s & scl_p & sda_p & ~sda_s;
wire bus_stop  = scl_s & scl_p & ~sda_p & sda_s;

// Open drain: only a low level is ever driven
assign sda_out = 1'b0;

// ****************************************************************
// Protocol engine
// ****************************************************************
// Protocol states
localparam [3:0] ST_IDLE      = `TOLRB_ST_IDLE;
localparam [3:0] ST_ADDR      = `TOLRB_ST_ADDR;
localparam [3:0] ST_ADDR_ACK  = `TOLRB_ST_ADDR_ACK;
localparam [3:0] ST_INSTR     = `TOLRB_ST_INSTR;
localparam [3:0] ST_INSTR_ACK = `TOLRB_ST_INSTR_ACK;
localparam [3:0] ST_WDATA     = `TOLRB_ST_WDATA;
localparam [3:0] ST_WDATA_ACK = `TOLRB_ST_WDATA_ACK;
localparam [3:0] ST_RDATA     = `TOLRB_ST_RDATA;
localparam [3:0] ST_RACK      = `TOLRB_ST_RACK;

reg [3:0] state;
reg [3:0] bit_cnt;
reg [7:0] shift;
reg [7:0] tx;
reg [2:0] cmd;
reg [4:0] loc;
reg       rw;
reg       master_ack;
reg [1:0] strap_cnt;

wire [7:0] next_byte = read_byte(cmd, loc);

always @(posedge clk or negedge nrst) begin
	if (!nrst) begin
		scl_p         <= 1'b1;
		sda_p         <= 1'b1;
		sda_oe_n      <= 1'b1;
		state         <= ST_IDLE;
		bit_cnt       <= `TOLRB_BIT_ZERO;
		shift         <= `TOLRB_EMPTY_BYTE;
		tx            <= `TOLRB_EMPTY_BYTE;
		cmd           <= `TOLRB_RESET_CMD;
		loc           <= `TOLRB_RESET_LOC;
		rw            <= 1'b0;
		master_ack    <= 1'b0;
		strap_cnt     <= `TOLRB_STRAP_ZERO;
		bus_address   <= `TOLRB_ADDR_00;
		address_valid <= 1'b0;
	end else begin
		scl_p <= scl_s;
		sda_p <= sda_s;
		// Straps are caught once, after the synchronisers have settled
		if (!address_valid) begin
			if (strap_cnt == `TOLRB_STRAP_SETTLE) begin
				bus_address   <= strap_address(pin_sync[3], pin_sync[2]);
				address_valid <= 1'b1;
			end else begin
				strap_cnt <= strap_cnt + `TOLRB_STRAP_STEP;
			end
		end
		if (bus_start && address_valid) begin
			// Start or repeated start; pointer and operation survive it
			state    <= ST_ADDR;
			bit_cnt  <= `TOLRB_BIT_ZERO;
			sda_oe_n <= 1'b1;
		end else if (bus_stop) begin
			state    <= ST_IDLE;
			sda_oe_n <= 1'b1;
		end else begin
			case (state)
				ST_ADDR, ST_INSTR, ST_WDATA: begin
					if (scl_rise) begin
						shift   <= {shift[6:0], sda_s};
						bit_cnt <= bit_cnt + `TOLRB_BIT_STEP;
					end else if (scl_fall && bit_cnt == `TOLRB_BITS_PER_BYTE) begin
						bit_cnt <= `TOLRB_BIT_ZERO;
						if (state == ST_ADDR) begin
							if (shift[7:1] == bus_address) begin
								rw       <= shift[`TOLRB_RW_BIT];
								sda_oe_n <= 1'b0;
								state    <= ST_ADDR_ACK;
							end else begin
								state <= ST_IDLE;
							end
						end else if (state == ST_INSTR) begin
							// Any time, no mode needed to reach the memory
							cmd      <= shift[`TOLRB_CMD_MSB:`TOLRB_CMD_LSB];
							loc      <= shift[`TOLRB_LOC_MSB:`TOLRB_LOC_LSB];
							sda_oe_n <= 1'b0;
							state    <= ST_INSTR_ACK;
						end else begin
							// Data is acknowledged and dropped: locations are fixed
							sda_oe_n <= 1'b0;
							state    <= ST_WDATA_ACK;
						end
					end
				end
				ST_ADDR_ACK: begin
					if (scl_fall) begin
						if (rw) begin
							tx       <= next_byte;
							sda_oe_n <= next_byte[`TOLRB_BYTE_MSB];
							state    <= ST_RDATA;
						end else begin
							sda_oe_n <= 1'b1;
							state    <= ST_INSTR;
						end
					end
				end
				ST_INSTR_ACK, ST_WDATA_ACK: begin
					if (scl_fall) begin
						sda_oe_n <= 1'b1;
						state    <= ST_WDATA;
					end
				end
				ST_RDATA: begin
					if (scl_fall) begin
						if (bit_cnt == `TOLRB_LAST_BIT) begin
							sda_oe_n <= 1'b1;
							state    <= ST_RACK;
						end else begin
							tx       <= {tx[6:0], 1'b0};
							sda_oe_n <= tx[6];
							bit_cnt  <= bit_cnt + `TOLRB_BIT_STEP;
						end
					end
				end
				ST_RACK: begin
					if (scl_rise) begin
						master_ack <= ~sda_s;
						if (!sda_s)
							loc <= loc + `TOLRB_LOC_STEP;
					end else if (scl_fall) begin
						bit_cnt <= `TOLRB_BIT_ZERO;
						if (master_ack) begin
							tx       <= next_byte;
							sda_oe_n <= next_byte[`TOLRB_BYTE_MSB];
							state    <= ST_RDATA;
						end else begin
							// No acknowledge: release and wait for stop
							state <= ST_IDLE;
						end
					end
				end
				ST_IDLE: begin
					sda_oe_n <= 1'b1;
				end
				default: begin
					state    <= ST_IDLE;
					sda_oe_n <= 1'b1;
				end
			endcase
		end
	end
end

endmodule // tolrb_target

// file: tb/tolrb_target_chk.sv
/*
 * Checker for the tolerance readback target: strap address, bus release, drive timing.
 * Assumes it is bound to tolrb_target and scl_in changes only at clk edges.
 */
`timescale 1ns/1ps
`include "tolrb_defines.vh"
module tolrb_chk (
	// Clock and reset
	input wire       clk,
	input wire       nrst,
	// Two-wire bus
	input wire       scl_in,
	input wire       sda_in,
	input wire       sda_out,
	input wire       sda_oe_n,
	// Straps and status
	input wire       bus_id_strap_low,
	input wire       bus_id_strap_high,
	input wire [6:0] bus_address,
	input wire       address_valid
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// ****************************************************************
	// Properties
	// ****************************************************************
	sequence s_drive; $fell(sda_oe_n); endsequence
	sequence s_held; !sda_oe_n [*4]; endsequence
	sequence s_stop; scl_in && $rose(sda_in); endsequence
	property p_map; $rose(address_valid) |-> bus_address == (bus_id_strap_high ?
		(bus_id_strap_low ? `TOLRB_ADDR_11 : `TOLRB_ADDR_10) :
		(bus_id_strap_low ? `TOLRB_ADDR_01 : `TOLRB_ADDR_00)); endproperty
	property p_keep; address_valid |=> address_valid && $stable(bus_address); endproperty
	property p_mute; !address_valid |-> sda_oe_n; endproperty
	property p_scl; $changed(sda_oe_n) |-> !scl_in; endproperty
	property p_start; scl_in && $fell(sda_in) |-> sda_oe_n; endproperty
	property p_od; sda_out == 1'h0; endproperty
	property p_held; s_drive |-> s_held; endproperty
	property p_stop; s_stop |=> sda_oe_n [*4]; endproperty
	a_map: assert property (p_map) else $error("strap address wrong");
	a_keep: assert property (p_keep) else $error("address not kept");
	a_mute: assert property (p_mute) else $error("drive before address");
	a_scl: assert property (p_scl) else $error("data moved with clock high");
	a_start: assert property (p_start) else $error("drive at start");
	a_od: assert property (p_od) else $error("data driven high");
	a_held: assert property (p_held) else $error("drive too short");
	a_stop: assert property (p_stop) else $error("drive after stop");
endmodule // tolrb_chk
bind tolrb_target tolrb_chk u_chk (.clk(clk), .nrst(nrst), .scl_in(scl_in),
	.sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
	.bus_id_strap_low(bus_id_strap_low), .bus_id_strap_high(bus_id_strap_high),
	.bus_address(bus_address), .address_valid(address_valid));

// file: tb/tolrb_host.sv
/*
 * Two-wire bus controller model: start, stop and nine-bit byte transfers.
 * Assumes an open-drain data wire with pull-up resolved by the bench.
 */
`timescale 1ns/1ps
module tolrb_host (
	// Clock
	input  wire clk,
	// Two-wire bus
	input  wire sda_w,
	output reg  scl,
	output reg  sda
);
	initial scl = 1'h1;
	initial sda = 1'h1;
	// ****************************************************************
	// Bus tasks: bit low phase 6 clocks, high phase 2; start and stop hold clock high 4
	// ****************************************************************
	task w(input integer n);
		repeat (n) @(posedge clk);
	endtask
	task bit_x(input b, output s);
		scl <= 1'h0;
		w(2);
		sda <= b;
		w(4);
		scl <= 1'h1;
		w(1);
		s = sda_w;
		w(1);
	endtask
	task start;
		if (!(scl && sda_w)) begin
			scl <= 1'h0;
			w(2);
			sda <= 1'h1;
			w(4);
			scl <= 1'h1;
			w(4);
		end
		sda <= 1'h0;
		w(4);
	endtask
	task stop;
		scl <= 1'h0;
		w(2);
		sda <= 1'h0;
		w(4);
		scl <= 1'h1;
		w(4);
		sda <= 1'h1;
		w(8);
	endtask
	// Last bit: acknowledge in from target, or own acknowledge out
	task xfer(input [7:0] d, input a, output [7:0] q, output r);
		integer i;
		for (i = 7; i >= 0; i = i - 1)
			bit_x(d[i], q[i]);
		bit_x(a, r);
	endtask
endmodule // tolrb_host

// file: tb/tb_tolrb_target.sv
/*
 * Self-checking bench for the tolerance readback target.
 * Assumes the host model drives the bus and the data wire is pulled up.
 */
`timescale 1ns/1ps
`include "tolrb_defines.vh"
module tb_tolrb_target;
	localparam [7:0] SIGN_INT = 8'h9c;
	localparam [7:0] FRACTION = 8'h0f;
	reg        clk = 1'h0;
	reg        nrst = 1'h0;
	reg        strap_hi = 1'h1;
	reg        strap_lo = 1'h0;
	reg  [6:0] tgt = `TOLRB_ADDR_10;
	reg [15:0] tenths;
	wire       scl;
	wire       sda_rel;
	wire       sda_out;
	wire       sda_oe_n;
	wire       sda_w = sda_rel & (sda_oe_n | sda_out);
	wire [6:0] bus_address;
	wire       address_valid;
	integer    fails = 0;
	integer    tests_run = 0;
	reg  [7:0] q;
	reg        r;
	always #12.5 clk = ~clk;
	tolrb_host HOST (.clk(clk), .sda_w(sda_w), .scl(scl), .sda(sda_rel));
	tolrb_target #(.TOL_SIGN_INT(SIGN_INT), .TOL_FRACTION(FRACTION)) DUT (
		.clk(clk), .nrst(nrst), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n), .bus_id_strap_low(strap_lo), .bus_id_strap_high(strap_hi),
		.bus_address(bus_address), .address_valid(address_valid));
	// ****************************************************************
	// Tasks
	// ****************************************************************
	task chk(input string n, input [7:0] e, input [7:0] s);
		tests_run = tests_run + 1;
		if (s !== e) begin
			fails = fails + 1;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task results;
		$display("compares %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task adr(input [6:0] a, input rw, input e);
		HOST.xfer({a, rw}, 1'h1, q, r);
		chk("address ack", {7'h00, e}, {7'h00, r});
	endtask
	task point(input [7:0] ins);
		HOST.start;
		adr(tgt, 1'h0, 1'h0);
		HOST.xfer(ins, 1'h1, q, r);
		chk("instruction ack", 8'h00, {7'h00, r});
	endtask
	task fetch(input [7:0] ins, input two, input [7:0] e0, input [7:0] e1);
		point(ins);
		HOST.start;
		adr(tgt, 1'h1, 1'h0);
		HOST.xfer(8'hff, !two, q, r);
		chk("first byte", e0, q);
		if (two) begin
			HOST.xfer(8'hff, 1'h1, q, r);
			chk("second byte", e1, q);
		end
		HOST.stop;
		$display("test with instruction %h done", ins);
	endtask
	initial begin
		#400000;
		fails = fails + 1;
		results;
	end
	initial begin
		repeat (3) @(posedge clk);
		chk("reset release", 8'h01, {7'h00, sda_oe_n});
		chk("reset valid", 8'h00, {7'h00, address_valid});
		repeat (2) @(posedge clk);
		nrst <= 1'h1;
		repeat (10) @(posedge clk);
		chk("strap address", {1'h0, `TOLRB_ADDR_10}, {1'h0, bus_address});
		$display("test with reset and straps done");
		// Straps move after capture; the old address must still answer
		strap_hi <= 1'h0;
		fetch(8'h3e, 1'h0, SIGN_INT, 8'h00);
		fetch(8'h3f, 1'h0, FRACTION, 8'h00);
		fetch(8'h3e, 1'h1, SIGN_INT, FRACTION);
		// Fraction rounded to tenths of a percent, as software would use it
		tenths = {8'h00, q} * 16'h000a + 16'h0080;
		chk("fraction tenths", 8'h01, tenths[15:8]);
		fetch(8'h1e, 1'h0, 8'h00, 8'h00);
		point(8'h3e);
		HOST.xfer(8'h00, 1'h1, q, r);
		chk("write ack", 8'h00, {7'h00, r});
		HOST.stop;
		$display("test with data write done");
		fetch(8'h3e, 1'h0, SIGN_INT, 8'h00);
		HOST.start;
		adr(`TOLRB_ADDR_00, 1'h0, 1'h1);
		HOST.stop;
		$display("test with other address done");
		// Second power-up with both straps high selects the last address
		nrst     <= 1'h0;
		strap_lo <= 1'h1;
		strap_hi <= 1'h1;
		repeat (5) @(posedge clk);
		chk("reset valid again", 8'h00, {7'h00, address_valid});
		nrst <= 1'h1;
		repeat (10) @(posedge clk);
		chk("strap address 11", {1'h0, `TOLRB_ADDR_11}, {1'h0, bus_address});
		tgt = `TOLRB_ADDR_11;
		fetch(8'h3f, 1'h0, FRACTION, 8'h00);
		results;
	end
endmodule // tb_tolrb_target
